//--- include/flash_poll_pkg.sv
/*
   Constants, register map and state types of the flash status poller.
   Assumes a 40 MHz system clock and a byte-wide parallel NOR flash outside.
*/
// Overview of operation
// - Start status check with two back-to-back reads.
// - Equal toggle values mean the operation finished.
// - Still toggling with timeout flag high: recheck.
// - Toggling after timeout flag: failed, send reset.
// - Toggling, flag low: restart from double read.
// - Any timeout failure is followed by reset command.
// - Window check skippable only under 50 us spacing.
// - Read window flag before and after sector command.
// - Flag high after command: selection maybe rejected.
// - Status reads use the program or sector address.
package flash_poll_pkg;

   // ==========================================================
   // Timing
   localparam int CLK_NS   = 25;
   localparam int T_RD_NS  = 100;
   localparam int T_WP_NS  = 50;
   localparam int T_GAP_NS = 50;
   localparam int T_SKIP_US = 50;
   localparam int SYNC_CYC = 2;
   localparam int RD_CYC   = (T_RD_NS + CLK_NS - 1) / CLK_NS;
   localparam int WR_CYC   = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int GAP_CYC  = (T_GAP_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [7:0] RD_LAST  = 8'(RD_CYC + SYNC_CYC - 1);
   localparam logic [7:0] WR_LAST  = 8'(WR_CYC - 1);
   localparam logic [7:0] GAP_LAST = 8'(GAP_CYC - 1);

   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_ADDR    = 8'h04;
   localparam logic [7:0] OFS_WDATA   = 8'h08;
   localparam logic [7:0] OFS_STAT    = 8'h0C;
   localparam logic [7:0] OFS_IRQ_ST  = 8'h10;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h14;
   localparam logic [7:0] OFS_IRQ_EN  = 8'h18;

   // ==========================================================
   // Field positions
   localparam int CTRL_POLL = 0;
   localparam int CTRL_WR   = 1;
   localparam int CTRL_RD   = 2;
   localparam int CTRL_ADD  = 3;
   localparam int STAT_BUSY = 0;
   localparam int STAT_OK   = 1;
   localparam int STAT_FAIL = 2;
   localparam int STAT_REJ  = 3;
   localparam int STAT_RDY  = 4;
   localparam int STAT_DATA = 8;
   localparam int IRQ_DONE  = 0;
   localparam int IRQ_FAIL  = 1;
   localparam int IRQ_REJ   = 2;
   localparam int TOG_BIT   = 6;
   localparam int TMO_BIT   = 5;
   localparam int WIN_BIT   = 3;

   // ==========================================================
   // Flash commands
   localparam logic [7:0] CMD_RESET = 8'hF0;
   localparam logic [7:0] CMD_SECT  = 8'h30;

   typedef enum logic [3:0] {O_IDLE, P_R1, P_R2, P_CMP, P_R3, P_CMP3, O_RST,
                             O_WR, O_RD, A_PRE, A_CMD, A_POST} op_e;
   typedef enum logic [1:0] {B_IDLE, B_ACT, B_GAP} bus_e;

endpackage

//--- core/flash_poll.sv
/*
   Host-side controller for a parallel NOR flash: runs the toggle-bit status
   procedure, single read and write cycles, and guarded additional sector
   selection, under a classic Wishbone register slave with interrupt.
   Assumes the flash data pins are asynchronous and are synchronised here,
   and that the bench resolves the data bus from flash_dq_oe_o.
*/
// Added by the designer: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none

module flash_poll
#(
   parameter int AW = 20
)
(
   // Clock and reset.
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // Wishbone slave.
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [7:0]           wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic      [31:0]          wb_dat_o,
   output logic                      wb_ack_o,
   // Interrupt.
   output logic                      irq_o,
   // Flash pins.
   output logic      [AW-1:0]        flash_addr_o,
   input  wire logic [7:0]           flash_dq_i,
   output logic      [7:0]           flash_dq_o,
   output logic                      flash_dq_oe_o,
   output logic                      flash_ce_n_o,
   output logic                      flash_oe_n_o,
   output logic                      flash_we_n_o,
   input  wire logic                 ready_busy_n_i
);
   import flash_poll_pkg::*;

   // Address width must fit a register word.
   if (AW < 1 || AW > 32)
   begin : g_chk
      $error("flash_poll: AW out of range");
   end

   // ==========================================================
   // State
   typedef struct packed {
      op_e          op;
      bus_e         bst;
      logic         breq;
      logic         bwe;
      logic         bdone;
      logic [7:0]   bcnt;
      logic [7:0]   bdat;
      logic [7:0]   rdat;
      logic         tog_a;
      logic         tog_b;
      logic         f5;
      logic [1:0]   nrd;
      logic         ok;
      logic         fail;
      logic         rej;
      logic [AW-1:0] addr;
      logic [7:0]   wdata;
      logic [2:0]   ist;
      logic [2:0]   ien;
      logic         ack;
      logic [31:0]  dat;
      logic [7:0]   dq1;
      logic [7:0]   dq2;
      logic         rb1;
      logic         rb2;
   } st_s;

   st_s          s_ff;
   st_s          nxt_s;
   logic [2:0]   ev;
   logic [2:0]   clr;
   logic         wr;
   logic         rd;
   logic [5:0]   idx;
   logic [31:0]  mask;
   logic [31:0]  merged;

   // ==========================================================
   // Next state
   always_comb
   begin
      nxt_s = s_ff;
      ev = 3'h0;
      clr = 3'h0;
      nxt_s.bdone = 1'b0;
      // Two-stage synchronisers for the asynchronous flash inputs.
      nxt_s.dq1 = flash_dq_i;
      nxt_s.dq2 = s_ff.dq1;
      nxt_s.rb1 = ready_busy_n_i;
      nxt_s.rb2 = s_ff.rb1;

      // Bus cycle engine; the gap forces the output enable high between reads.
      case (s_ff.bst)
         B_IDLE:
         begin
            if (s_ff.breq)
            begin
               nxt_s.bst = B_ACT;
               nxt_s.breq = 1'b0;
               nxt_s.bcnt = 8'h00;
            end
         end
         B_ACT:
         begin
            if (s_ff.bcnt == (s_ff.bwe ? WR_LAST : RD_LAST))
            begin
               nxt_s.bst = B_GAP;
               nxt_s.bcnt = 8'h00;
               nxt_s.bdone = 1'b1;
               if (!s_ff.bwe)
               begin
                  nxt_s.rdat = s_ff.dq2;
               end
            end
            else
            begin
               nxt_s.bcnt = s_ff.bcnt + 8'h01;
            end
         end
         B_GAP:
         begin
            if (s_ff.bcnt == GAP_LAST)
            begin
               nxt_s.bst = B_IDLE;
            end
            else
            begin
               nxt_s.bcnt = s_ff.bcnt + 8'h01;
            end
         end
         default:
         begin
            nxt_s.bst = B_IDLE;
         end
      endcase

      // Operation sequencer; each bus state waits for its cycle to finish.
      case (s_ff.op)
         O_IDLE:
         begin
         end
         P_R1:
         begin
            if (s_ff.bdone)
            begin
               nxt_s.tog_a = s_ff.rdat[TOG_BIT];
               nxt_s.nrd = s_ff.nrd + 2'h1;
               nxt_s.op = P_R2;
            end
         end
         P_R2:
         begin
            if (s_ff.bdone)
            begin
               nxt_s.tog_b = s_ff.rdat[TOG_BIT];
               nxt_s.f5 = s_ff.rdat[TMO_BIT];
               nxt_s.nrd = s_ff.nrd + 2'h1;
               nxt_s.op = P_CMP;
            end
         end
         P_CMP:
         begin
            if (s_ff.tog_a == s_ff.tog_b)
            begin
               nxt_s.ok = 1'b1;
               ev[IRQ_DONE] = 1'b1;
               nxt_s.op = O_IDLE;
            end
            else if (s_ff.f5)
            begin
               nxt_s.tog_a = s_ff.tog_b;
               nxt_s.op = P_R3;
            end
            else
            begin
               nxt_s.nrd = 2'h0;
               nxt_s.op = P_R1;
            end
         end
         P_R3:
         begin
            if (s_ff.bdone)
            begin
               nxt_s.tog_b = s_ff.rdat[TOG_BIT];
               nxt_s.op = P_CMP3;
            end
         end
         P_CMP3:
         begin
            if (s_ff.tog_a == s_ff.tog_b)
            begin
               nxt_s.ok = 1'b1;
               ev[IRQ_DONE] = 1'b1;
               nxt_s.op = O_IDLE;
            end
            else
            begin
               nxt_s.op = O_RST;
            end
         end
         O_RST:
         begin
            if (s_ff.bdone)
            begin
               nxt_s.fail = 1'b1;
               ev[IRQ_FAIL] = 1'b1;
               ev[IRQ_DONE] = 1'b1;
               nxt_s.op = O_IDLE;
            end
         end
         O_WR, O_RD, A_POST:
         begin
            if (s_ff.bdone)
            begin
               ev[IRQ_DONE] = 1'b1;
               nxt_s.op = O_IDLE;
               if (s_ff.op == A_POST && s_ff.rdat[WIN_BIT])
               begin
                  nxt_s.rej = 1'b1;
                  ev[IRQ_REJ] = 1'b1;
               end
            end
         end
         A_PRE:
         begin
            if (s_ff.bdone)
            begin
               // The window flag is always checked; no spacing guarantee is assumed.
               if (s_ff.rdat[WIN_BIT])
               begin
                  nxt_s.rej = 1'b1;
                  ev[IRQ_REJ] = 1'b1;
                  ev[IRQ_DONE] = 1'b1;
                  nxt_s.op = O_IDLE;
               end
               else
               begin
                  nxt_s.op = A_CMD;
               end
            end
         end
         A_CMD:
         begin
            if (s_ff.bdone)
            begin
               nxt_s.op = A_POST;
            end
         end
         default:
         begin
            nxt_s.op = O_IDLE;
         end
      endcase

      // Wishbone slave: one-cycle registered answer, ack dropped after one cycle.
      // Writes take effect at the edge at which the master samples ack high.
      wr = wb_cyc_i && wb_stb_i && wb_we_i && s_ff.ack;
      rd = wb_cyc_i && wb_stb_i && !wb_we_i && !s_ff.ack;
      nxt_s.ack = wb_cyc_i && wb_stb_i && !s_ff.ack;
      idx = wb_adr_i[7:2];
      mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
      merged = (32'(s_ff.addr) & ~mask) | (wb_dat_i & mask);
      if (wr)
      begin
         if (idx == OFS_ADDR[7:2])
         begin
            nxt_s.addr = merged[AW-1:0];
         end
         if (idx == OFS_WDATA[7:2] && wb_sel_i[0])
         begin
            nxt_s.wdata = wb_dat_i[7:0];
         end
         if (idx == OFS_IRQ_EN[7:2] && wb_sel_i[0])
         begin
            nxt_s.ien = wb_dat_i[2:0];
         end
         if (idx == OFS_IRQ_CLR[7:2] && wb_sel_i[0])
         begin
            clr = wb_dat_i[2:0];
         end
         // A start while an operation runs is ignored.
         if (idx == OFS_CTRL[7:2] && wb_sel_i[0] && s_ff.op == O_IDLE
             && wb_dat_i[3:0] != 4'h0)
         begin
            nxt_s.ok = 1'b0;
            nxt_s.fail = 1'b0;
            nxt_s.rej = 1'b0;
            nxt_s.nrd = 2'h0;
            if (wb_dat_i[CTRL_POLL])
            begin
               nxt_s.op = P_R1;
            end
            else if (wb_dat_i[CTRL_WR])
            begin
               nxt_s.op = O_WR;
            end
            else if (wb_dat_i[CTRL_RD])
            begin
               nxt_s.op = O_RD;
            end
            else
            begin
               nxt_s.op = A_PRE;
            end
         end
      end
      if (rd)
      begin
         case (idx)
            OFS_ADDR[7:2]:   nxt_s.dat = 32'(s_ff.addr);
            OFS_WDATA[7:2]:  nxt_s.dat = {24'h000000, s_ff.wdata};
            OFS_STAT[7:2]:
            begin
               nxt_s.dat = 32'h00000000;
               nxt_s.dat[STAT_BUSY] = (s_ff.op != O_IDLE);
               nxt_s.dat[STAT_OK] = s_ff.ok;
               nxt_s.dat[STAT_FAIL] = s_ff.fail;
               nxt_s.dat[STAT_REJ] = s_ff.rej;
               nxt_s.dat[STAT_RDY] = s_ff.rb2;
               nxt_s.dat[STAT_DATA +: 8] = s_ff.rdat;
            end
            OFS_IRQ_ST[7:2]: nxt_s.dat = {29'h0, s_ff.ist};
            OFS_IRQ_EN[7:2]: nxt_s.dat = {29'h0, s_ff.ien};
            default:         nxt_s.dat = 32'h00000000;
         endcase
      end

      // Sticky events; a new event wins over a clear in the same cycle.
      nxt_s.ist = (s_ff.ist & ~clr) | ev;

      // Entering a bus state queues its cycle; status reads use the address register.
      if (nxt_s.op != s_ff.op)
      begin
         case (nxt_s.op)
            P_R1, P_R2, P_R3, O_RD, A_PRE, A_POST:
            begin
               nxt_s.breq = 1'b1;
               nxt_s.bwe = 1'b0;
            end
            O_RST:
            begin
               nxt_s.breq = 1'b1;
               nxt_s.bwe = 1'b1;
               nxt_s.bdat = CMD_RESET;
            end
            A_CMD:
            begin
               nxt_s.breq = 1'b1;
               nxt_s.bwe = 1'b1;
               nxt_s.bdat = CMD_SECT;
            end
            O_WR:
            begin
               nxt_s.breq = 1'b1;
               nxt_s.bwe = 1'b1;
               nxt_s.bdat = s_ff.wdata;
            end
            default:
            begin
            end
         endcase
      end
   end

   // State register.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_ff <= '0;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   // ==========================================================
   // Outputs
   assign wb_dat_o = s_ff.dat;
   assign wb_ack_o = s_ff.ack;
   assign irq_o = |(s_ff.ist & s_ff.ien);
   assign flash_addr_o = s_ff.addr;
   assign flash_dq_o = s_ff.bdat;
   assign flash_dq_oe_o = (s_ff.bst == B_ACT) && s_ff.bwe;
   assign flash_ce_n_o = !(s_ff.bst == B_ACT);
   assign flash_oe_n_o = !((s_ff.bst == B_ACT) && !s_ff.bwe);
   assign flash_we_n_o = !((s_ff.bst == B_ACT) && s_ff.bwe);

   // ==========================================================
   // Assertions
   localparam int RST_WAIT = 20;

   property p_two_reads;
      @(posedge clk_i) disable iff (rst_i) (s_ff.op == P_CMP) |-> (s_ff.nrd == 2'h2);
   endproperty
   a_two_reads: assert property (p_two_reads) else $error("compare before two reads");

   property p_done_equal;
      @(posedge clk_i) disable iff (rst_i)
         (s_ff.op == P_CMP && s_ff.tog_a == s_ff.tog_b) |=> (s_ff.op == O_IDLE && s_ff.ok);
   endproperty
   a_done_equal: assert property (p_done_equal) else $error("equal toggle not done");

   property p_recheck;
      @(posedge clk_i) disable iff (rst_i)
         (s_ff.op == P_CMP && s_ff.tog_a != s_ff.tog_b && s_ff.f5) |=> (s_ff.op == P_R3);
   endproperty
   a_recheck: assert property (p_recheck) else $error("no recheck after timeout flag");

   property p_fail_reset;
      @(posedge clk_i) disable iff (rst_i)
         (s_ff.op == P_CMP3 && s_ff.tog_a != s_ff.tog_b) |=> (s_ff.op == O_RST);
   endproperty
   a_fail_reset: assert property (p_fail_reset) else $error("failure not reset");

   property p_restart;
      @(posedge clk_i) disable iff (rst_i)
         (s_ff.op == P_CMP && s_ff.tog_a != s_ff.tog_b && !s_ff.f5)
         |=> (s_ff.op == P_R1 && s_ff.nrd == 2'h0);
   endproperty
   a_restart: assert property (p_restart) else $error("poll not restarted");

   property p_reset_cmd;
      @(posedge clk_i) disable iff (rst_i)
         $rose(s_ff.op == O_RST)
         |-> ##[1:RST_WAIT] (!flash_we_n_o && flash_dq_oe_o && flash_dq_o == CMD_RESET);
   endproperty
   a_reset_cmd: assert property (p_reset_cmd) else $error("reset command missing");

   property p_addr_stable;
      @(posedge clk_i) disable iff (rst_i)
         (!flash_oe_n_o && !$past(flash_oe_n_o)) |-> $stable(flash_addr_o);
   endproperty
   a_addr_stable: assert property (p_addr_stable) else $error("address moved in read");

   property p_reject;
      @(posedge clk_i) disable iff (rst_i)
         (s_ff.op == A_POST && s_ff.bdone && s_ff.rdat[WIN_BIT])
         |=> (s_ff.rej && s_ff.ist[IRQ_REJ]);
   endproperty
   a_reject: assert property (p_reject) else $error("rejection not reported");

   property p_outcome;
      @(posedge clk_i) disable iff (rst_i)
         (s_ff.op != O_IDLE) ##1 (s_ff.op == O_IDLE) |-> s_ff.ist[IRQ_DONE];
   endproperty
   a_outcome: assert property (p_outcome) else $error("end without outcome");

endmodule

`default_nettype wire

//--- tb/flash_model.sv
/*
   Behavioural byte-wide flash status model for the poller bench.
   Assumes the bench resolves the data bus and pulses start_i and erase_i.
*/
`timescale 1ns/10ps
`default_nettype none

module flash_model
#(
   parameter int WIN_CYC = 20
)
(
   // Bench control.
   input  wire logic       clk_i,
   input  wire logic       start_i,
   input  wire logic       erase_i,
   input  wire logic [3:0] n_i,
   input  wire logic [1:0] mode_i,
   input  wire logic       d7_i,
   // Flash pins.
   input  wire logic       oe_n_i,
   input  wire logic       ce_n_i,
   input  wire logic       we_n_i,
   input  wire logic [7:0] dq_i,
   output logic      [7:0] dq_o,
   output logic            ready_busy_n_o,
   // Command counts seen.
   output logic      [7:0] rst_cnt_o,
   output logic      [7:0] sel_cnt_o
);
   // ==========================================
   // State
   logic       busy = 1'b0;
   logic       tog  = 1'b0;
   logic       tmo  = 1'b0;
   logic       win  = 1'b1;
   logic [7:0] last = 8'h00;
   logic [7:0] wdat = 8'h00;
   logic [7:0] val;
   int         cnt  = 0;
   int         wtim = 0;

   initial
   begin
      rst_cnt_o = 8'h00;
      sel_cnt_o = 8'h00;
   end

   // Status byte; off a read the bus shows the inverse of the last byte.
   assign val = {busy ? ~d7_i : d7_i, tog, tmo, 1'b0, win, 3'b000};
   assign dq_o = (!ce_n_i && !oe_n_i) ? val : ~last;
   assign ready_busy_n_o = ~busy;

   // Operation start, erase window timer and write data capture.
   always @(posedge clk_i)
   begin
      if (start_i)
      begin
         busy = 1'b1;
         tmo = 1'b0;
         cnt = 0;
      end
      if (erase_i)
      begin
         win = 1'b0;
         wtim = WIN_CYC;
      end
      else if (wtim > 0)
      begin
         wtim = wtim - 1;
         win = (wtim == 0);
      end
      if (!we_n_i && !ce_n_i)
         wdat = dq_i;
   end

   // End of a read: toggle while busy, raise the timeout flag by mode.
   always @(posedge oe_n_i)
   begin
      last = val;
      if (busy)
      begin
         cnt = cnt + 1;
         if (cnt >= n_i && mode_i != 2'h1)
            busy = 1'b0;
         else
            tog = ~tog;
         if (mode_i != 2'h0 && cnt + 1 >= n_i)
            tmo = 1'b1;
      end
   end

   // End of a write: reset command, or a sector select while the window is open.
   always @(posedge we_n_i)
   begin
      if (wdat == 8'hF0)
      begin
         busy = 1'b0;
         tmo = 1'b0;
         rst_cnt_o = rst_cnt_o + 8'h01;
      end
      else if (wdat == 8'h30 && !win)
      begin
         wtim = WIN_CYC;
         sel_cnt_o = sel_cnt_o + 8'h01;
      end
   end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
/*
   Self-checking bench of the flash status poller against a flash model.
   Assumes the poller and its package from core/ and include/.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_top;
   import flash_poll_pkg::*;

   localparam int WIN = 20;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'hF;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdat;
   logic        ack;
   logic        irq;
   logic [7:0]  dq_h;
   logic [7:0]  dq_f;
   logic [7:0]  bus;
   logic        dq_oe;
   logic        ce_n;
   logic        oe_n;
   logic        we_n;
   logic        rb_n;
   logic        start = 1'b0;
   logic        erase = 1'b0;
   logic [3:0]  n = 4'h2;
   logic [1:0]  mode = 2'h0;
   logic        d7 = 1'b0;
   logic [7:0]  rst_cnt;
   logic [7:0]  sel_cnt;
   logic [7:0]  c0;
   logic [31:0] q;
   logic [31:0] rnd;
   logic [7:0]  bval;
   logic [19:0] faddr;
   int          err_count = 0;
   int          tests_run = 0;

   // Clock at 40 MHz and data bus resolution.
   always #12.5 clk = ~clk;
   assign bus = dq_oe ? dq_h : dq_f;

   flash_poll #(.AW(20)) DUT
   (
      .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
      .irq_o(irq), .flash_addr_o(faddr), .flash_dq_i(bus), .flash_dq_o(dq_h),
      .flash_dq_oe_o(dq_oe), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n),
      .flash_we_n_o(we_n), .ready_busy_n_i(rb_n)
   );

   flash_model #(.WIN_CYC(WIN)) mdl
   (
      .clk_i(clk), .start_i(start), .erase_i(erase), .n_i(n), .mode_i(mode),
      .d7_i(d7), .oe_n_i(oe_n), .ce_n_i(ce_n), .we_n_i(we_n), .dq_i(bus),
      .dq_o(dq_f), .ready_busy_n_o(rb_n), .rst_cnt_o(rst_cnt), .sel_cnt_o(sel_cnt)
   );

   // Verdict and end of run.
   task automatic end_sim();
      if (err_count == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // A wait that ran out counts as a mismatch and ends the run.
   task automatic guard(input logic hit);
      if (hit)
      begin
         err_count++;
         end_sim();
      end
   endtask

   // Compare one value and count the result.
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One classic Wishbone cycle; read data is taken at the ack edge.
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      adr <= a;
      we <= w;
      wd <= d;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (ack !== 1'b1 && k < 50);
      guard(k >= 50);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask

   // Read status until the poller is idle.
   task automatic wait_idle();
      int k;
      k = 0;
      do
      begin
         wb(OFS_STAT, 1'b0, 32'h0);
         k++;
      end
      while (q[STAT_BUSY] !== 1'b0 && k < 200);
      guard(k >= 200);
   endtask

   // Expected {rej, fail, ok, busy} and last byte bits 7 and 5 per mode.
   function automatic logic [3:0] poll_flags(input logic [1:0] m);
      return (m == 2'h1) ? 4'b0100 : 4'b0010;
   endfunction
   function automatic logic [1:0] last_bits(input logic [1:0] m, input logic b7);
      return {(m == 2'h1) ? ~b7 : b7, m != 2'h0};
   endfunction

   // Main sequence.
   initial
   begin
      void'($urandom(32'h392C3ED3));
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      wb(OFS_STAT, 1'b1, 32'hFFFFFFFF);
      wb(OFS_STAT, 1'b0, 32'h0);
      check("stat_reset", 32'h10, 32'(q[4:0]));
      wb(8'h1C, 1'b0, 32'h0);
      check("unmapped", 32'h0, q);
      wb(OFS_IRQ_EN, 1'b0, 32'h0);
      check("irq_en_reset", 32'h0, q);
      wb(OFS_IRQ_EN, 1'b1, 32'h2);
      // Address lanes, then one single write and one single read at that address.
      rnd = $urandom;
      wb(OFS_ADDR, 1'b1, rnd);
      sel <= 4'h1;
      wb(OFS_ADDR, 1'b1, ~rnd);
      sel <= 4'hF;
      wb(OFS_ADDR, 1'b0, 32'h0);
      check("addr_reg", 32'({rnd[19:8], ~rnd[7:0]}), q);
      check("addr_pin", 32'({rnd[19:8], ~rnd[7:0]}), 32'(faddr));
      bval = 8'h40 | 8'($urandom % 16);
      wb(OFS_WDATA, 1'b1, 32'(bval));
      wb(OFS_CTRL, 1'b1, 32'h1 << CTRL_WR);
      wait_idle();
      check("wr_byte", 32'(bval), 32'(mdl.wdat));
      wb(OFS_CTRL, 1'b1, 32'h1 << CTRL_RD);
      wait_idle();
      check("rd_byte", 32'(mdl.val), 32'(q[15:8]));
      // Toggle polling against done, failing and late-timeout devices.
      for (int i = 0; i < 9; i++)
      begin
         mode <= 2'(i % 3);
         n <= 4'(2 + $urandom % 8);
         d7 <= 1'($urandom);
         start <= 1'b1;
         @(posedge clk);
         start <= 1'b0;
         c0 = rst_cnt;
         wb(OFS_IRQ_CLR, 1'b1, 32'h7);
         wb(OFS_CTRL, 1'b1, 32'h1 << CTRL_POLL);
         wb(OFS_STAT, 1'b0, 32'h0);
         check("busy_ready", 32'h1, 32'({q[STAT_RDY], q[STAT_BUSY]}));
         wait_idle();
         check("flags", 32'(poll_flags(mode)), 32'(q[3:0]));
         check("last_byte", 32'(last_bits(mode, d7)), 32'({q[15], q[13]}));
         check("reset_cmd", 32'(c0 + (mode == 2'h1)), 32'(rst_cnt));
         check("irq", 32'(mode == 2'h1), 32'(irq));
         if (mode == 2'h1)
         begin
            wb(OFS_IRQ_EN, 1'b1, 32'h0);
            check("irq_masked", 32'h0, 32'(irq));
            wb(OFS_IRQ_ST, 1'b0, 32'h0);
            check("irq_st", 32'h3, q);
            wb(OFS_IRQ_EN, 1'b1, 32'h2);
            wb(OFS_IRQ_CLR, 1'b1, 32'h2);
            check("irq_clr", 32'h0, 32'(irq));
         end
      end
      // Additional sector selection swept across the window expiry.
      for (int j = 0; j <= WIN; j++)
      begin
         erase <= 1'b1;
         @(posedge clk);
         erase <= 1'b0;
         repeat (j) @(posedge clk);
         c0 = sel_cnt;
         wb(OFS_CTRL, 1'b1, 32'h1 << CTRL_ADD);
         wait_idle();
         check("rej", 32'(sel_cnt == c0), 32'(q[STAT_REJ]));
      end
      end_sim();
   end
endmodule
`default_nettype wire
